// [rtl/cfwl_top.sv]
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "cfwl_defs.svh"
module cfwl_top
    import cfwl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_alive,
    input wire logic pll_bypass,
    input wire logic ext_nmi_in_n,
    input wire logic dbg_wake_n,
    input wire logic [31:0] gpio_a_n,
    input wire logic cpu_idle_exec,
    input wire logic cpu_irq_taken,
    output logic wdog_reset_out_n,
    output logic wdog_wake_irq,
    output logic device_reset_n,
    output logic limp_clk_sel,
    output logic missing_clock_flag,
    output logic osc_clock_en,
    output logic pll_en,
    output logic cpu_clock_in_en,
    output logic system_clock_out_en,
    output logic pin_hold,
    output logic cpu_resume
);
    cfwl_state_s r_ff; // Registered state
    cfwl_state_s nxt_r; // Next state

    logic acc; // APB access phase with ready
    logic setup; // APB setup phase
    logic gp_wake; // Any selected GPIO held low
    logic [1:0] lp_sel; // Mode select field
    logic wd_run; // Watchdog may count this tick
    logic [31:0] gp_agree; // GPIO stages 2 and 3 agree, per line

    assign acc = psel && penable && r_ff.pready;
    assign setup = psel && !penable;
    assign lp_sel = r_ff.lpctrl[`CFWL_LP_SEL_HI:`CFWL_LP_SEL_LO];
    assign gp_wake = |(~r_ff.gp_n & r_ff.wakesel);
    // A line keeps its old filtered level while its two last stages still differ
    assign gp_agree = ~(r_ff.gp_s2 ^ r_ff.gp_s3);

    // Next-state logic for the whole block
    always_comb begin
        nxt_r = r_ff;
        // Three-stage synchronisers; filtered levels take the value only when stages 2 and 3 agree
        nxt_r.osc_s = {r_ff.osc_s[1:0], osc_alive};
        nxt_r.nmi_s = {r_ff.nmi_s[1:0], ext_nmi_in_n};
        nxt_r.dbg_s = {r_ff.dbg_s[1:0], dbg_wake_n};
        nxt_r.gp_s1 = gpio_a_n;
        nxt_r.gp_s2 = r_ff.gp_s1;
        nxt_r.gp_s3 = r_ff.gp_s2;
        if (r_ff.osc_s[1] == r_ff.osc_s[2]) begin
            nxt_r.osc_ok = r_ff.osc_s[2];
        end
        if (r_ff.nmi_s[1] == r_ff.nmi_s[2]) begin
            nxt_r.nmi_n = r_ff.nmi_s[2];
        end
        if (r_ff.dbg_s[1] == r_ff.dbg_s[2]) begin
            nxt_r.dbg_n = r_ff.dbg_s[2];
        end
        nxt_r.gp_n = (r_ff.gp_n & ~gp_agree) | (r_ff.gp_s3 & gp_agree);

        // Clock loss detection
        if (r_ff.osc_ok) begin
            nxt_r.seen_osc = 1'b1;
            nxt_r.limp = 1'b0;
        end else if (r_ff.seen_osc && r_ff.st != CFWL_HALT) begin
            nxt_r.limp = 1'b1;
        end
        if (nxt_r.limp && !r_ff.limp) begin
            nxt_r.rst_cnt = `CFWL_CLKFAIL_RST_CYC;
        end else if (r_ff.rst_cnt != 5'h00) begin
            nxt_r.rst_cnt = r_ff.rst_cnt - 5'h01;
        end
        // Limp source reaches the CPU clock mux only in bypass
        nxt_r.limp_route = nxt_r.limp && pll_bypass;

        // Oscillator tick; none while halted or while the oscillator is missing
        nxt_r.osc_tick = 1'b0;
        if (r_ff.osc_ok && r_ff.st != CFWL_HALT) begin
            if (r_ff.osc_div == `CFWL_OSC_DIV - 4'h1) begin
                nxt_r.osc_div = 4'h0;
                nxt_r.osc_tick = 1'b1;
            end else begin
                nxt_r.osc_div = r_ff.osc_div + 4'h1;
            end
        end

        // Watchdog counter, frozen on the limp clock
        wd_run = r_ff.osc_tick && r_ff.osc_ok;
        if (r_ff.wdctrl[`CFWL_WD_DIS_BIT]) begin
            nxt_r.wd_cnt = 8'h00;
            nxt_r.wd_pulse = 10'h000;
        end else if (wd_run) begin
            if (r_ff.wd_pulse != 10'h000) begin
                nxt_r.wd_pulse = r_ff.wd_pulse - 10'h001;
            end else if (r_ff.wd_cnt == `CFWL_WD_MAX) begin
                nxt_r.wd_pulse = `CFWL_WD_PULSE_LEN;
                nxt_r.wd_cnt = 8'h00;
            end else begin
                nxt_r.wd_cnt = r_ff.wd_cnt + 8'h01;
            end
        end
        // Pulse is routed to reset or to the wake interrupt by mode bit
        nxt_r.wd_rst_n = !(nxt_r.wd_pulse != 10'h000 && !r_ff.wdctrl[`CFWL_WD_IRQ_BIT]);
        nxt_r.wd_irq = nxt_r.wd_pulse != 10'h000 && r_ff.wdctrl[`CFWL_WD_IRQ_BIT];

        // APB slave: ready registered one cycle after setup, so every access has no wait state
        nxt_r.pready = setup;
        nxt_r.pslverr = 1'b0;
        if (setup) begin
            nxt_r.prdata = 32'h00000000;
            unique case (paddr)
                `CFWL_OFS_LPCTRL: nxt_r.prdata = {23'h000000, r_ff.lpctrl};
                `CFWL_OFS_WAKESEL: nxt_r.prdata = r_ff.wakesel;
                `CFWL_OFS_WDCTRL: nxt_r.prdata = {30'h00000000, r_ff.wdctrl};
                `CFWL_OFS_WDCNT: nxt_r.prdata = {24'h000000, r_ff.wd_cnt};
                `CFWL_OFS_WDKEY: nxt_r.prdata = 32'h00000000;
                `CFWL_OFS_STATUS: nxt_r.prdata = {26'h0000000, r_ff.wd_irq_flag, r_ff.st,
                                                  r_ff.limp, r_ff.miss_flag};
                default: nxt_r.pslverr = 1'b1; // Unmapped: error answer
            endcase
        end
        if (acc && pwrite) begin
            unique case (paddr)
                `CFWL_OFS_LPCTRL: nxt_r.lpctrl = pwdata[8:0];
                `CFWL_OFS_WAKESEL: nxt_r.wakesel = pwdata;
                `CFWL_OFS_WDCTRL: nxt_r.wdctrl = pwdata[1:0];
                `CFWL_OFS_WDKEY: begin
                    // Second key only counts if no other key-register write came between it and the first
                    if (pwdata[7:0] == `CFWL_WD_KEY1) begin
                        nxt_r.key_armed = 1'b1;
                    end else if (pwdata[7:0] == `CFWL_WD_KEY2 && r_ff.key_armed) begin
                        nxt_r.key_armed = 1'b0;
                        nxt_r.wd_cnt = 8'h00;
                    end else begin
                        nxt_r.key_armed = 1'b0;
                    end
                end
                `CFWL_OFS_STATUS: begin
                    // Write one to clear; a set in the same cycle wins below
                    if (pwdata[`CFWL_ST_MISS_BIT]) begin
                        nxt_r.miss_flag = 1'b0;
                    end
                    if (pwdata[`CFWL_ST_WDIRQ_BIT]) begin
                        nxt_r.wd_irq_flag = 1'b0;
                    end
                end
                default: nxt_r.key_armed = r_ff.key_armed;
            endcase
        end
        if (nxt_r.limp && !r_ff.limp) begin
            nxt_r.miss_flag = 1'b1;
        end
        if (nxt_r.wd_irq) begin
            nxt_r.wd_irq_flag = 1'b1;
        end

        // GPIO wake qualification, counted in oscillator ticks while a selected pin stays low
        if (!gp_wake) begin
            nxt_r.qual_cnt = 6'h00;
        end else if (r_ff.osc_tick && r_ff.qual_cnt != r_ff.lpctrl[`CFWL_LP_QUAL_HI:`CFWL_LP_QUAL_LO]) begin
            nxt_r.qual_cnt = r_ff.qual_cnt + 6'h01;
        end

        // Low-power controller
        nxt_r.cpu_resume = 1'b0;
        unique case (r_ff.st)
            CFWL_RUN: begin
                if (cpu_idle_exec) begin
                    if (lp_sel[1]) begin
                        nxt_r.st = CFWL_HALT;
                    end else if (lp_sel[0]) begin
                        nxt_r.st = CFWL_STBY;
                    end else begin
                        nxt_r.st = CFWL_IDLE;
                    end
                end
            end
            CFWL_IDLE: begin
                // Nothing else is done here; the CPU leaves on an interrupt, a watchdog interrupt or NMI
                if (cpu_irq_taken || r_ff.wd_irq || !r_ff.nmi_n) begin
                    nxt_r.st = CFWL_RUN;
                end
            end
            CFWL_STBY: begin
                // Debugger path is sampled on pclk, so it needs no CPU clock
                if ((r_ff.wd_irq && r_ff.lpctrl[`CFWL_LP_WDWAKE]) || !r_ff.nmi_n || !r_ff.dbg_n
                    || (gp_wake && r_ff.qual_cnt == r_ff.lpctrl[`CFWL_LP_QUAL_HI:`CFWL_LP_QUAL_LO])) begin
                    nxt_r.st = CFWL_WAKE;
                end
            end
            CFWL_HALT: begin
                // No oscillator ticks here, so GPIO is taken on its synchronised level
                if (!r_ff.nmi_n || !r_ff.dbg_n || gp_wake) begin
                    nxt_r.st = CFWL_WAKE;
                end
            end
            CFWL_WAKE: begin
                // Clocks come back one cycle before the CPU resumes
                nxt_r.st = CFWL_RUN;
                nxt_r.cpu_resume = 1'b1;
            end
            default: nxt_r.st = CFWL_RUN;
        endcase

        // No tick may be launched into the first halted cycle
        if (nxt_r.st == CFWL_HALT) begin
            nxt_r.osc_tick = 1'b0;
        end
        // Clock enables follow the next state so they line up with it
        nxt_r.osc_en = nxt_r.st != CFWL_HALT;
        nxt_r.pll_en = nxt_r.st != CFWL_HALT;
        nxt_r.cpu_en = nxt_r.st == CFWL_RUN || nxt_r.st == CFWL_IDLE || nxt_r.st == CFWL_WAKE;
        nxt_r.sys_en = nxt_r.st == CFWL_RUN || nxt_r.st == CFWL_IDLE || nxt_r.st == CFWL_WAKE;
        nxt_r.pin_hold = nxt_r.st != CFWL_RUN;
        nxt_r.dev_rst_n = nxt_r.rst_cnt == 5'h00;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff <= '0;
            r_ff.st <= CFWL_RUN;
            r_ff.lpctrl <= `CFWL_LPCTRL_RST;
            r_ff.wakesel <= `CFWL_WAKESEL_RST;
            r_ff.wdctrl <= `CFWL_WDCTRL_RST;
            // NMI, debugger and GPIO synchronisers start at the idle high level, so no false wake follows reset
            r_ff.nmi_s <= 3'h7;
            r_ff.dbg_s <= 3'h7;
            r_ff.gp_s1 <= 32'hFFFFFFFF;
            r_ff.gp_s2 <= 32'hFFFFFFFF;
            r_ff.gp_s3 <= 32'hFFFFFFFF;
            r_ff.nmi_n <= 1'b1;
            r_ff.dbg_n <= 1'b1;
            r_ff.gp_n <= 32'hFFFFFFFF;
            r_ff.wd_rst_n <= 1'b1;
            r_ff.dev_rst_n <= 1'b1;
            r_ff.osc_en <= 1'b1;
            r_ff.pll_en <= 1'b1;
            r_ff.cpu_en <= 1'b1;
            r_ff.sys_en <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = r_ff.prdata;
    assign pready = r_ff.pready;
    assign pslverr = r_ff.pslverr;
    assign wdog_reset_out_n = r_ff.wd_rst_n;
    assign wdog_wake_irq = r_ff.wd_irq;
    assign device_reset_n = r_ff.dev_rst_n;
    assign limp_clk_sel = r_ff.limp_route;
    assign missing_clock_flag = r_ff.miss_flag;
    assign osc_clock_en = r_ff.osc_en;
    assign pll_en = r_ff.pll_en;
    assign cpu_clock_in_en = r_ff.cpu_en;
    assign system_clock_out_en = r_ff.sys_en;
    assign pin_hold = r_ff.pin_hold;
    assign cpu_resume = r_ff.cpu_resume;

    // Helper: length of the current low reset pulse in pclk cycles, cleared a cycle after it ends
    logic [15:0] low_len_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_len_ff <= 16'h0000;
        end else if (!r_ff.wd_rst_n) begin
            low_len_ff <= low_len_ff + 16'h0001;
        end else begin
            low_len_ff <= 16'h0000;
        end
    end

    // Watchdog checks
    AST_WD_PULSE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(wdog_reset_out_n) && !$past(r_ff.wdctrl[0]) && $past(r_ff.osc_ok, 2) |-> low_len_ff >= 16'h07F8)
        else $error("Watchdog reset pulse too short");
    AST_WD_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !r_ff.osc_ok && !$past(r_ff.osc_ok) && !acc |=> $stable(r_ff.wd_cnt) || r_ff.wdctrl[0])
        else $error("Watchdog counted without oscillator");
    AST_WD_KEY: assert property (@(posedge pclk) disable iff (!presetn)
        acc && pwrite && paddr == 12'h010 && pwdata[7:0] == 8'hAA && r_ff.key_armed |=> r_ff.wd_cnt == 8'h00)
        else $error("Key sequence did not clear counter");
    AST_WD_DIS: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.wdctrl[0] |=> wdog_reset_out_n && !wdog_wake_irq)
        else $error("Pulse while watchdog disabled");

    // Clock-loss checks
    AST_MISS_RST: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r_ff.limp) |-> missing_clock_flag && !device_reset_n ##1 !device_reset_n [*8])
        else $error("Clock loss without flag and reset");
    AST_LIMP: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.limp |-> r_ff.seen_osc)
        else $error("Limp mode before oscillator seen");

    // Low-power checks
    AST_HALT_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_HALT |-> !osc_clock_en && !pll_en && !cpu_clock_in_en && !r_ff.osc_tick)
        else $error("Clocks running in halt");
    AST_STBY_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_STBY |-> osc_clock_en && !cpu_clock_in_en && !system_clock_out_en && pin_hold)
        else $error("Standby clock gating wrong");
    AST_IDLE_SYS: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_IDLE |-> system_clock_out_en && cpu_clock_in_en)
        else $error("System clock gated in idle");
    AST_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        $past(r_ff.st) == CFWL_RUN && r_ff.st != CFWL_RUN |-> $past(cpu_idle_exec))
        else $error("Low-power entry without idle instruction");
    AST_HALT_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
        $past(r_ff.st) == CFWL_HALT && r_ff.st == CFWL_WAKE |=> r_ff.st == CFWL_RUN && cpu_resume)
        else $error("Wake did not resume the CPU");

    // Wake and routing checks
    AST_IDLE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_IDLE && cpu_irq_taken |=> r_ff.st == CFWL_RUN)
        else $error("Idle not left on interrupt");
    AST_IDLE_NMI: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_IDLE && !r_ff.nmi_n |=> r_ff.st == CFWL_RUN)
        else $error("Idle not left on NMI");
    AST_STBY_WD: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_STBY && wdog_wake_irq && r_ff.lpctrl[`CFWL_LP_WDWAKE] |=> r_ff.st == CFWL_WAKE)
        else $error("Standby not left on watchdog");
    AST_STBY_DBG: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_STBY && !r_ff.dbg_n |=> r_ff.st == CFWL_WAKE)
        else $error("Standby not left on debugger");
    AST_HALT_STAY: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_HALT && r_ff.nmi_n && r_ff.dbg_n && !gp_wake |=> r_ff.st == CFWL_HALT)
        else $error("Halt left without a wake source");
    AST_HALT_DBG: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_HALT && !r_ff.dbg_n |=> r_ff.st == CFWL_WAKE)
        else $error("Halt not left on debugger");
    AST_LIMP_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.limp && $past(pll_bypass) |-> limp_clk_sel)
        else $error("Limp clock not routed in bypass");
    AST_WAKE_CLK: assert property (@(posedge pclk) disable iff (!presetn)
        r_ff.st == CFWL_WAKE |-> cpu_clock_in_en && system_clock_out_en)
        else $error("Clocks off while waking");
endmodule : cfwl_top
`default_nettype wire

// [common/cfwl_defs.svh]
`ifndef CFWL_DEFS_SVH
`define CFWL_DEFS_SVH
// Register byte offsets
`define CFWL_OFS_LPCTRL 12'h000
`define CFWL_OFS_WAKESEL 12'h004
`define CFWL_OFS_WDCTRL 12'h008
`define CFWL_OFS_WDCNT 12'h00C
`define CFWL_OFS_WDKEY 12'h010
`define CFWL_OFS_STATUS 12'h014
// Control and status register fields
`define CFWL_LP_SEL_HI 1
`define CFWL_LP_SEL_LO 0
`define CFWL_LP_QUAL_HI 7
`define CFWL_LP_QUAL_LO 2
`define CFWL_LP_WDWAKE 8
`define CFWL_WD_DIS_BIT 0
`define CFWL_WD_IRQ_BIT 1
`define CFWL_ST_MISS_BIT 0
`define CFWL_ST_LIMP_BIT 1
`define CFWL_ST_STATE_HI 4
`define CFWL_ST_STATE_LO 2
`define CFWL_ST_WDIRQ_BIT 5
// Reset values
`define CFWL_LPCTRL_RST 9'h000
`define CFWL_WAKESEL_RST 32'h00000000
`define CFWL_WDCTRL_RST 2'h0
// Watchdog constants
`define CFWL_WD_MAX 8'hFF
`define CFWL_WD_KEY1 8'h55
`define CFWL_WD_KEY2 8'hAA
`define CFWL_WD_PULSE_LEN 10'h200
// Clock rates: pclk 50 MHz, oscillator tick derived by divider
`define CFWL_PCLK_MHZ 50
`define CFWL_OSC_DIV 4'h4
`define CFWL_CLKFAIL_RST_CYC 5'h10
`endif

// [common/cfwl_pkg.sv]
`include "cfwl_defs.svh"
package cfwl_pkg;
    // Low-power controller states
    typedef enum logic [2:0] {
        CFWL_RUN = 3'h0,
        CFWL_IDLE = 3'h1,
        CFWL_STBY = 3'h2,
        CFWL_HALT = 3'h3,
        CFWL_WAKE = 3'h4
    } cfwl_lp_e;

    // Whole state of the block
    typedef struct packed {
        logic [2:0] osc_s;       // Oscillator-alive synchroniser
        logic [2:0] nmi_s;       // NMI pin synchroniser
        logic [2:0] dbg_s;       // Debugger wake synchroniser
        logic [31:0] gp_s1;      // GPIO synchroniser stage 1
        logic [31:0] gp_s2;
        logic [31:0] gp_s3;
        logic osc_ok;            // Filtered oscillator alive
        logic nmi_n;             // Filtered NMI level
        logic dbg_n;             // Filtered debugger level
        logic [31:0] gp_n;       // Filtered GPIO levels
        logic seen_osc;          // Oscillator was present once
        logic limp;              // Running on limp clock
        logic miss_flag;         // Sticky missing clock flag
        logic [4:0] rst_cnt;     // Device reset stretch
        logic [3:0] osc_div;     // Oscillator tick divider
        logic osc_tick;
        logic [7:0] wd_cnt;
        logic [9:0] wd_pulse;    // Remaining pulse ticks
        logic key_armed;
        logic wd_irq_flag;       // Sticky watchdog interrupt flag
        logic [8:0] lpctrl;
        logic [31:0] wakesel;
        logic [1:0] wdctrl;
        logic [5:0] qual_cnt;
        cfwl_lp_e st;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wd_rst_n;
        logic wd_irq;
        logic dev_rst_n;
        logic limp_route;
        logic osc_en;
        logic pll_en;
        logic cpu_en;
        logic sys_en;
        logic pin_hold;
        logic cpu_resume;
    } cfwl_state_s;
endpackage : cfwl_pkg

// [dv/cfwl_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// CPU core, interrupt expander and port-A wake pins seen from the block
module cfwl_far_model
    import cfwl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go_idle,         // Bench asks the CPU to run its idle instruction
    input wire logic [2:0] wake_kind, // 0 none, 1 NMI, 2 debugger, 3 GPIO, 4 interrupt
    input wire logic [4:0] wake_pin,  // Port-A line used for GPIO wake
    input wire logic pin_hold,
    output logic cpu_idle_exec,
    output logic cpu_irq_taken,
    output logic ext_nmi_in_n,
    output logic dbg_wake_n,
    output logic [31:0] gpio_a_n
);
    // Wake lines rest high on their pull-ups; a source pulls low and stays low
    // until the block is back in run, so it is never too short to be seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_idle_exec <= 1'b0;
            cpu_irq_taken <= 1'b0;
            ext_nmi_in_n <= 1'b1;
            dbg_wake_n <= 1'b1;
            gpio_a_n <= 32'hFFFFFFFF;
        end else begin
            cpu_idle_exec <= go_idle;
            cpu_irq_taken <= (wake_kind == 3'h4) && pin_hold;
            ext_nmi_in_n <= !((wake_kind == 3'h1) && pin_hold);
            dbg_wake_n <= !((wake_kind == 3'h2) && pin_hold);
            gpio_a_n <= ~(((wake_kind == 3'h3) && pin_hold) ? (32'h1 << wake_pin) : 32'h0);
        end
    end
endmodule : cfwl_far_model
`default_nettype wire

// [dv/tb_clock_fail_watchdog_lowpower.sv]
`timescale 1ns/100ps
`default_nettype none
`include "cfwl_defs.svh"
// Register access, watchdog, clock loss and low-power walks
module tb_clock_fail_watchdog_lowpower
    import cfwl_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, gpio_a_n, rd, a;
    logic pready, pslverr, err, cpu_idle_exec, cpu_irq_taken, ext_nmi_in_n, dbg_wake_n;
    logic osc_alive = 1'b0, pll_bypass = 1'b0, go_idle = 1'b0;
    logic [2:0] wake_kind = 3'h0;
    logic wdog_reset_out_n, wdog_wake_irq, device_reset_n, limp_clk_sel, missing_clock_flag;
    logic osc_clock_en, pll_en, cpu_clock_in_en, system_clock_out_en, pin_hold, cpu_resume;
    int fails = 0, checks_done = 0, n;
    // Mode walk: select code and wake source; halt with source 0 tries the watchdog first
    logic [1:0] lp_sel [10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
    logic [2:0] lp_kind [10] = '{3'h4, 3'h1, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h2, 3'h3};

    // 50 MHz clock
    always #10 pclk = ~pclk;

    cfwl_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .osc_alive(osc_alive), .pll_bypass(pll_bypass), .ext_nmi_in_n(ext_nmi_in_n),
        .dbg_wake_n(dbg_wake_n), .gpio_a_n(gpio_a_n), .cpu_idle_exec(cpu_idle_exec),
        .cpu_irq_taken(cpu_irq_taken), .wdog_reset_out_n(wdog_reset_out_n),
        .wdog_wake_irq(wdog_wake_irq), .device_reset_n(device_reset_n), .limp_clk_sel(limp_clk_sel),
        .missing_clock_flag(missing_clock_flag), .osc_clock_en(osc_clock_en), .pll_en(pll_en),
        .cpu_clock_in_en(cpu_clock_in_en), .system_clock_out_en(system_clock_out_en),
        .pin_hold(pin_hold), .cpu_resume(cpu_resume));

    // The far side: CPU, expander and wake pins
    cfwl_far_model far (.pclk(pclk), .presetn(presetn), .go_idle(go_idle), .wake_kind(wake_kind),
        .wake_pin(5'h05), .pin_hold(pin_hold), .cpu_idle_exec(cpu_idle_exec),
        .cpu_irq_taken(cpu_irq_taken), .ext_nmi_in_n(ext_nmi_in_n), .dbg_wake_n(dbg_wake_n),
        .gpio_a_n(gpio_a_n));

    // Counts and verdict; the only way the run ends
    task give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // Compare with case equality so an unknown never matches
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s exp %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            $display("mismatch pready exp 1 seen %b", pready);
            give_verdict();
        end
    endtask : apb

    // Output picked by index for the bounded waits
    function automatic logic sig(input int w);
        case (w)
            0: return pin_hold;
            1: return wdog_reset_out_n;
            default: return device_reset_n;
        endcase
    endfunction : sig

    // Cycles until the watched output reaches lvl; running out ends the run
    task wait_for(input int w, input logic lvl, input int lim);
        n = 0;
        while (sig(w) !== lvl && n < lim) begin
            @(negedge pclk);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("mismatch wait%0d exp %b seen %b", w, lvl, sig(w));
            give_verdict();
        end
    endtask : wait_for

    initial begin
        // Oscillator absent from power-up: limp handling must stay quiet
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(negedge pclk);
        chk("no_loss", 3'h1, {missing_clock_flag, limp_clk_sel, device_reset_n});
        chk("clk_en", 5'h1E, {osc_clock_en, pll_en, cpu_clock_in_en, system_clock_out_en, pin_hold});
        @(posedge pclk);
        osc_alive <= 1'b1;
        // Reset values, read-back, unmapped word refused
        apb(1'b0, `CFWL_OFS_LPCTRL, 32'h0);
        chk("lpctrl", `CFWL_LPCTRL_RST, rd);
        apb(1'b0, `CFWL_OFS_WDCTRL, 32'h0);
        chk("wdctrl", `CFWL_WDCTRL_RST, rd);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        apb(1'b1, `CFWL_OFS_WAKESEL, 32'h00000020);
        apb(1'b0, `CFWL_OFS_WAKESEL, 32'h0);
        chk("wakesel", 32'h00000020, rd);
        // A foreign key write between the halves spoils the sequence
        repeat (200) @(posedge pclk);
        apb(1'b1, `CFWL_OFS_WDKEY, `CFWL_WD_KEY1);
        apb(1'b1, `CFWL_OFS_WDKEY, 32'h12);
        apb(1'b1, `CFWL_OFS_WDKEY, `CFWL_WD_KEY2);
        apb(1'b0, `CFWL_OFS_WDCNT, 32'h0);
        chk("wdcnt_kept", 1, rd >= 32'h20);
        apb(1'b1, `CFWL_OFS_WDKEY, `CFWL_WD_KEY1);
        apb(1'b1, `CFWL_OFS_WDKEY, `CFWL_WD_KEY2);
        apb(1'b0, `CFWL_OFS_WDCNT, 32'h0);
        chk("wdcnt_clr", 1, rd <= 32'h1);
        // Overflow: reset pulse of 512 ticks, four clocks each
        wait_for(1, 1'b0, 1300);
        wait_for(1, 1'b1, 2200);
        chk("pulse_len", 32'd2048, n);
        // Disabled watchdog stays silent well past an overflow
        apb(1'b1, `CFWL_OFS_WDCTRL, 32'h1);
        n = 0;
        repeat (1300) begin
            @(negedge pclk);
            n += (wdog_reset_out_n !== 1'b1 || wdog_wake_irq !== 1'b0);
        end
        chk("wd_off", 0, n);
        // Clock loss in bypass: limp routing, 16-cycle reset, flag, frozen counter
        apb(1'b1, `CFWL_OFS_WDCTRL, 32'h0);
        @(posedge pclk);
        pll_bypass <= 1'b1;
        osc_alive <= 1'b0;
        wait_for(2, 1'b0, 40);
        wait_for(2, 1'b1, 40);
        chk("loss_rst", 32'd16, n);
        chk("limp", 2'h3, {missing_clock_flag, limp_clk_sel});
        apb(1'b0, `CFWL_OFS_WDCNT, 32'h0);
        a = rd;
        repeat (100) @(posedge pclk);
        apb(1'b0, `CFWL_OFS_WDCNT, 32'h0);
        chk("wd_frozen", a, rd);
        apb(1'b0, `CFWL_OFS_STATUS, 32'h0);
        chk("status", 2'h3, rd[1:0]);
        osc_alive <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b1, `CFWL_OFS_STATUS, 32'h1);
        apb(1'b0, `CFWL_OFS_STATUS, 32'h0);
        chk("flag_clr", 0, rd[0]);
        pll_bypass <= 1'b0;
        // Every mode with each of its wake sources
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, `CFWL_OFS_WDCTRL, 32'h1);
            apb(1'b1, `CFWL_OFS_WDCTRL, (lp_kind[i] == 3'h0) ? 32'h2 : 32'h1);
            apb(1'b1, `CFWL_OFS_LPCTRL, {23'h0, lp_kind[i] == 3'h0, 6'h06, lp_sel[i]});
            @(posedge pclk);
            go_idle <= 1'b1;
            @(posedge pclk);
            go_idle <= 1'b0;
            wait_for(0, 1'b1, 10);
            chk("lp_en", {lp_sel[i] < 2, lp_sel[i] < 2, lp_sel[i] == 0, lp_sel[i] == 0},
                {osc_clock_en, pll_en, cpu_clock_in_en, system_clock_out_en});
            apb(1'b0, `CFWL_OFS_STATUS, 32'h0);
            chk("state", (lp_sel[i] == 0) ? 1 : ((lp_sel[i] == 1) ? 2 : 3), rd[4:2]);
            if (lp_sel[i] > 1 && lp_kind[i] == 3'h0) begin
                repeat (1500) @(negedge pclk);
                chk("halt_wd", 1, pin_hold);
            end
            @(posedge pclk);
            wake_kind <= (lp_kind[i] == 3'h0 && lp_sel[i] > 1) ? 3'h1 : lp_kind[i];
            wait_for(0, 1'b0, 3000);
            chk("resume", {lp_sel[i] != 2'h0, 1'b1}, {cpu_resume, cpu_clock_in_en});
            if (lp_kind[i] == 3'h3 && lp_sel[i] == 1) begin
                chk("qual", 1, n >= 24);
            end
            @(posedge pclk);
            wake_kind <= 3'h0;
        end
        give_verdict();
    end
endmodule : tb_clock_fail_watchdog_lowpower
`default_nettype wire
